/* logic/optics_actuator_control.sv */
// Optics support actuators: steppers, supply relays and fold interlock
// Behaviour
// - High step moves one step, CCW with direction low, CW with high.
// - Six normally closed end-of-travel switches are forwarded to the host.
// - Load converter maps bipolar span onto 0..4095, 2047 meaning zero force.
// - Active-low sensor power output enables the position sensor supply relay.
// - Low fold-out drive enables out relay pair; low fold-in the in pair.
// - Out relay pair applies motor current opposite in polarity to in pair.
// - Fold supply relay enabled only while fold motor power is low.
// - Fold never driven either way unless both mirror covers are open.
// - Cover open status goes high when its cover open switch opens.
// - Covers-clear is both cover switches ANDed directly; gates each fold command.
// - Fold-in status needs fold-in switch and both torque switches closed.
`timescale 1ns/1ps
`default_nettype none
module optics_actuator_control
  import optics_ctrl_pkg::*;
#(
  parameter int axes     = axis_count,
  parameter int cnt_w    = step_count_width,
  parameter int load_w   = load_width
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  // Host stepper commands, one lane per axis
  input  wire logic [axes-1:0]         step_start,
  input  wire logic [axes-1:0]         step_clockwise,
  input  wire logic [axes*cnt_w-1:0]   step_total,
  input  wire logic [axes-1:0]         step_abort,
  // Stepper controller pins
  output logic      [axes-1:0]         stepper_step,
  output logic      [axes-1:0]         stepper_dir,
  output logic      [axes-1:0]         step_busy,
  output logic      [axes*cnt_w-1:0]   step_remain,
  // Host supply commands, active low
  input  wire logic                    stepper_power_n,
  input  wire logic                    position_sensor_power_n,
  input  wire logic                    fold_motor_power_n,
  // Supply relay enables, active low
  output logic                         stepper_supply_relay_n,
  output logic                         sensor_supply_relay_n,
  output logic                         fold_supply_relay_n,
  // Host fold commands, active low
  input  wire logic                    fold_out_cmd_n,
  input  wire logic                    fold_in_cmd_n,
  // Fold direction relay enables, active low
  output logic                         fold_in_relay_a_n,
  output logic                         fold_in_relay_b_n,
  output logic                         fold_out_relay_a_n,
  output logic                         fold_out_relay_b_n,
  // Cover switches, closed (low) when the cover is fully closed
  input  wire logic                    left_cover_switch,
  input  wire logic                    right_cover_switch,
  output logic                         left_cover_open,
  output logic                         right_cover_open,
  output logic                         covers_clear,
  // Fold position switches, closed is high
  input  wire logic                    fold_in_switch,
  input  wire logic                    torque_switch_1,
  input  wire logic                    torque_switch_2,
  input  wire logic                    fold_out_switch,
  output logic                         fold_in_seen,
  output logic                         fold_out_seen_n,
  // End-of-travel switches, normally closed (low), high when tripped
  input  wire logic [2*axes-1:0]       limit_switch,
  output logic      [2*axes-1:0]       limit_status,
  // Load-cell counts from converter, one per axis
  input  wire logic [axes*load_w-1:0]  load_count,
  output logic      [axes-1:0]         load_in_window,
  output logic      [axes*load_w-1:0]  load_offset
);

  // Signed force offset of a count around the zero-force point
  function automatic logic [load_w-1:0] zero_offset(
    input logic [load_w-1:0] count
  );
    zero_offset = count - load_w'(load_zero_force);
  endfunction : zero_offset

  logic fold_out_req;
  logic fold_in_req;
  logic fold_out_d;
  logic fold_in_d;
  logic fold_out_q;
  logic fold_in_q;

  // Stepper channels; step stays low between moves
  for (genvar i = 0; i < axes; i++) begin : g_axis
    stepper_channel #(
      .count_width (cnt_w)
    ) u_chan (
      .clock      (clock),
      .rst_b      (rst_b),
      .start      (step_start[i] & ~stepper_power_n),
      .clockwise  (step_clockwise[i]),
      .step_total (step_total[i*cnt_w +: cnt_w]),
      .abort      (step_abort[i] | stepper_power_n),
      .step_q     (stepper_step[i]),
      .dir_q      (stepper_dir[i]),
      .busy       (step_busy[i]),
      .remain_q   (step_remain[i*cnt_w +: cnt_w])
    );
  end

  // Supply relays follow host enables; no excitation unless asked
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stepper_supply_relay_n <= relay_off_n;
      sensor_supply_relay_n  <= relay_off_n;
      fold_supply_relay_n    <= relay_off_n;
    end else begin
      stepper_supply_relay_n <= stepper_power_n;
      sensor_supply_relay_n  <= position_sensor_power_n;
      fold_supply_relay_n    <= fold_motor_power_n;
    end
  end

  // Cover status: a switch opening reads high
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      left_cover_open  <= 1'b0;
      right_cover_open <= 1'b0;
    end else begin
      left_cover_open  <= left_cover_switch;
      right_cover_open <= right_cover_switch;
    end
  end

  // Interlock uses the switches directly so relays drop in one cycle
  assign covers_clear = left_cover_switch & right_cover_switch;
  assign fold_out_req = covers_clear & ~fold_out_cmd_n;
  assign fold_in_req  = covers_clear & ~fold_in_cmd_n;

  // Conflicting requests drive nothing rather than pick a winner
  always_comb begin
    fold_out_d = fold_out_req & ~fold_in_req;
    fold_in_d  = fold_in_req & ~fold_out_req;
  end

  // Direction drives; break before make on reversal
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fold_out_q <= 1'b0;
      fold_in_q  <= 1'b0;
    end else begin
      fold_out_q <= fold_out_d & ~fold_in_q;
      fold_in_q  <= fold_in_d & ~fold_out_q;
    end
  end

  // Out pair and in pair cross the motor with opposite polarity
  assign fold_out_relay_a_n = ~fold_out_q;
  assign fold_out_relay_b_n = ~fold_out_q;
  assign fold_in_relay_a_n  = ~fold_in_q;
  assign fold_in_relay_b_n  = ~fold_in_q;

  // Fold position status; fold-in needs the series string closed
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fold_in_seen    <= 1'b0;
      fold_out_seen_n <= 1'b1;
    end else begin
      fold_in_seen    <= fold_in_switch & torque_switch_1
                         & torque_switch_2;
      fold_out_seen_n <= ~fold_out_switch;
    end
  end

  // Limits forwarded to the host, registered once
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      limit_status <= '0;
    end else begin
      limit_status <= limit_switch;
    end
  end

  // Load-cell window flags; regulation itself is the processor's job
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      load_in_window <= '0;
      load_offset    <= '0;
    end else begin
      for (int i = 0; i < axes; i++) begin
        load_in_window[i] <=
          (load_count[i*load_w +: load_w] >= load_w'(load_window_low)) &&
          (load_count[i*load_w +: load_w] <= load_w'(load_window_high));
        load_offset[i*load_w +: load_w] <=
          zero_offset(load_count[i*load_w +: load_w]);
      end
    end
  end

endmodule : optics_actuator_control
`default_nettype wire

/* logic/optics_ctrl_pkg.sv */
// Constants and types shared by the optics actuator control logic
package optics_ctrl_pkg;

  // Stepper geometry and count widths
  localparam int          axis_count        = 3;
  localparam int          limit_count       = 2 * axis_count;
  localparam int          steps_per_rev     = 200;
  localparam int          step_count_width  = 16;
  localparam int          load_width        = 12;

  // Load-cell converter scale
  localparam logic [11:0] load_full_scale   = 12'hfff;  // 4095
  localparam logic [11:0] load_zero_force   = 12'h7ff;  // 2047
  localparam logic [11:0] load_window_low   = 12'h69f;  // 1695
  localparam logic [11:0] load_window_high  = 12'h70d;  // 1805

  // Step pulse timing: high time and low gap, in ns
  localparam int          clock_period_ns   = 100;
  localparam int          step_high_ns      = 1000;
  localparam int          step_gap_ns       = 1000;
  localparam int          step_high_cycles  =
    (step_high_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int          step_gap_cycles   =
    (step_gap_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int          timer_width       = 8;

  // Reset values of driven outputs
  localparam logic        relay_off_n       = 1'b1;

  // Stepper channel sequencer states
  typedef enum logic [1:0] {
    step_idle = 2'b00,
    step_high = 2'b01,
    step_gap  = 2'b10
  } step_state_type;

endpackage : optics_ctrl_pkg

/* logic/stepper_channel.sv */
// One stepper channel: emits counted step pulses with a direction level
`timescale 1ns/1ps
`default_nettype none
module stepper_channel
  import optics_ctrl_pkg::*;
#(
  parameter int count_width = step_count_width
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  // Command
  input  wire logic                   start,
  input  wire logic                   clockwise,
  input  wire logic [count_width-1:0] step_total,
  input  wire logic                   abort,
  // Controller pins
  output logic                        step_q,
  output logic                        dir_q,
  // Status
  output logic                        busy,
  output logic [count_width-1:0]      remain_q
);

  localparam logic [timer_width-1:0] high_load =
    timer_width'(step_high_cycles - 1);
  localparam logic [timer_width-1:0] gap_load =
    timer_width'(step_gap_cycles - 1);

  step_state_type         state_q;
  logic [timer_width-1:0] timer_q;

  assign busy = (state_q != step_idle);

  // Sequencer: step held low while idle keeps controller in standby
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q  <= step_idle;
      timer_q  <= '0;
      remain_q <= '0;
      step_q   <= 1'b0;
      dir_q    <= 1'b0;
    end else if (abort) begin
      state_q  <= step_idle;  // Drop step at once; motor stops
      step_q   <= 1'b0;
      remain_q <= '0;
    end else begin
      case (state_q)
        step_idle: begin
          step_q <= 1'b0;  // Standby between moves
          if (start && step_total != '0) begin
            dir_q    <= clockwise;  // Low CCW, high CW
            remain_q <= step_total;
            state_q  <= step_gap;
            timer_q  <= '0;  // Lets dir settle a cycle before step
          end
        end
        step_high: begin
          if (timer_q == '0) begin
            step_q   <= 1'b0;
            remain_q <= remain_q - count_width'(1);  // One pulse
            timer_q  <= gap_load;
            state_q  <= step_gap;
          end else begin
            timer_q <= timer_q - timer_width'(1);
          end
        end
        step_gap: begin
          if (timer_q != '0) begin
            timer_q <= timer_q - timer_width'(1);
          end else if (remain_q == '0) begin
            state_q <= step_idle;
          end else begin
            step_q  <= 1'b1;  // High step moves one step
            timer_q <= high_load;
            state_q <= step_high;
          end
        end
        default: begin
          state_q <= step_idle;
          step_q  <= 1'b0;
        end
      endcase
    end
  end

endmodule : stepper_channel
`default_nettype wire

/* tb/stepper_model.sv */
// Behavioural stepper controllers watching the step and direction pins
`timescale 1ns/1ps
`default_nettype none
module stepper_model (
  // Controller pins and excitation relay
  input  wire logic       clock,
  input  wire logic [2:0] step,
  input  wire logic [2:0] dir,
  input  wire logic       supply_n,
  // Net shaft position in steps, per axis
  output var  int         pos [3]
);
  // Power-up state; one process owns each variable, so no second driver
  logic [2:0] last_q = 3'h0;
  int         pos_q [3] = '{0, 0, 0};

  assign pos = pos_q;

  // A shaft moves only on a rising step with excitation present
  always @(posedge clock) begin
    last_q <= step;
    for (int i = 0; i < 3; i++) begin
      if (step[i] && !last_q[i] && !supply_n) begin
        pos_q[i] <= pos_q[i] + (dir[i] ? 1 : -1);
      end
    end
  end
endmodule : stepper_model
`default_nettype wire

/* tb/optics_chk.sv */
// Port checker for the optics actuator control block
`timescale 1ns/1ps
`default_nettype none
module optics_chk #(
  parameter int axes = 3
) (
  // Clock and reset
  input wire logic            clock,
  input wire logic            rst_b,
  // Stepper lane and supplies
  input wire logic [axes-1:0] stepper_step,
  input wire logic [axes-1:0] step_busy,
  input wire logic            stepper_power_n,
  input wire logic            stepper_supply_relay_n,
  input wire logic            fold_motor_power_n,
  input wire logic            fold_supply_relay_n,
  // Fold interlock
  input wire logic            fold_out_cmd_n,
  input wire logic            fold_in_cmd_n,
  input wire logic            covers_clear,
  input wire logic            fold_in_relay_a_n,
  input wire logic            fold_in_relay_b_n,
  input wire logic            fold_out_relay_a_n,
  input wire logic            fold_out_relay_b_n,
  input wire logic            left_cover_switch,
  input wire logic            left_cover_open
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Copies are judged only once the previous edge was out of reset
  property p_busy; stepper_step[0] |-> step_busy[0]; endproperty
  a_busy: assert property (p_busy) else $error("Step while idle");
  property p_width;
    $rose(stepper_step[0]) |-> ##9 stepper_step[0] ##1 !stepper_step[0];
  endproperty
  a_width: assert property (p_width) else $error("Step width");
  property p_spw;
    $past(rst_b) |-> stepper_supply_relay_n == $past(stepper_power_n);
  endproperty
  a_spw: assert property (p_spw) else $error("Stepper relay");
  property p_fpw;
    $past(rst_b) |-> fold_supply_relay_n == $past(fold_motor_power_n);
  endproperty
  a_fpw: assert property (p_fpw) else $error("Fold relay");
  property p_out;
    $past(rst_b) && !fold_out_relay_a_n
      |-> $past(covers_clear) && !$past(fold_out_cmd_n)
          && $past(fold_in_cmd_n);
  endproperty
  a_out: assert property (p_out) else $error("Out drive");
  property p_in;
    $past(rst_b) && !fold_in_relay_a_n
      |-> $past(covers_clear) && !$past(fold_in_cmd_n)
          && $past(fold_out_cmd_n);
  endproperty
  a_in: assert property (p_in) else $error("In drive");
  property p_pair;
    fold_out_relay_a_n == fold_out_relay_b_n
      && fold_in_relay_a_n == fold_in_relay_b_n;
  endproperty
  a_pair: assert property (p_pair) else $error("Pair split");
  property p_both; fold_in_relay_a_n || fold_out_relay_a_n; endproperty
  a_both: assert property (p_both) else $error("Both drives");
  property p_cov;
    $past(rst_b) |-> left_cover_open == $past(left_cover_switch);
  endproperty
  a_cov: assert property (p_cov) else $error("Cover status");
  // Main scenarios reached
  c_out: cover property (!fold_out_relay_a_n);
  c_in: cover property (!fold_in_relay_a_n);
  c_step: cover property ($rose(stepper_step[0]));
endmodule : optics_chk

bind optics_actuator_control optics_chk #(.axes(axes)) chk_i (
  .clock(clock), .rst_b(rst_b), .stepper_step(stepper_step),
  .step_busy(step_busy), .stepper_power_n(stepper_power_n),
  .stepper_supply_relay_n(stepper_supply_relay_n),
  .fold_motor_power_n(fold_motor_power_n),
  .fold_supply_relay_n(fold_supply_relay_n),
  .fold_out_cmd_n(fold_out_cmd_n), .fold_in_cmd_n(fold_in_cmd_n),
  .covers_clear(covers_clear), .fold_in_relay_a_n(fold_in_relay_a_n),
  .fold_in_relay_b_n(fold_in_relay_b_n),
  .fold_out_relay_a_n(fold_out_relay_a_n),
  .fold_out_relay_b_n(fold_out_relay_b_n),
  .left_cover_switch(left_cover_switch), .left_cover_open(left_cover_open)
);
`default_nettype wire

/* tb/optics_actuator_control_tb.sv */
// Self-checking bench for the optics actuator control block
`timescale 1ns/1ps
`default_nettype none
module optics_actuator_control_tb;
  // Stimulus and responses
  logic        clock, rst_b, stepper_power_n, position_sensor_power_n;
  logic        fold_motor_power_n, fold_out_cmd_n, fold_in_cmd_n;
  logic        left_cover_switch, right_cover_switch, fold_in_switch;
  logic        torque_switch_1, torque_switch_2, fold_out_switch;
  logic [2:0]  step_start, step_clockwise, step_abort, stepper_step;
  logic [2:0]  stepper_dir, step_busy, load_in_window, supply_drv;
  logic [47:0] step_total, step_remain;
  logic [35:0] load_count, load_offset;
  logic [5:0]  limit_switch, limit_status;
  logic [3:0]  fold_drv;
  logic        stepper_supply_relay_n, sensor_supply_relay_n;
  logic        fold_supply_relay_n, fold_in_relay_a_n, fold_in_relay_b_n;
  logic        fold_out_relay_a_n, fold_out_relay_b_n, left_cover_open;
  logic        right_cover_open, covers_clear, fold_in_seen, fold_out_seen_n;
  int          pos [3];
  int          mismatches, checks;

  // Grouped relay enables keep each compare on one line
  assign fold_drv = {fold_in_relay_a_n, fold_in_relay_b_n,
                     fold_out_relay_a_n, fold_out_relay_b_n};
  assign supply_drv = {stepper_supply_relay_n, sensor_supply_relay_n,
                       fold_supply_relay_n};

  optics_actuator_control DUT (
    .clock(clock), .rst_b(rst_b), .step_start(step_start),
    .step_clockwise(step_clockwise), .step_total(step_total),
    .step_abort(step_abort), .stepper_step(stepper_step),
    .stepper_dir(stepper_dir), .step_busy(step_busy),
    .step_remain(step_remain), .stepper_power_n(stepper_power_n),
    .position_sensor_power_n(position_sensor_power_n),
    .fold_motor_power_n(fold_motor_power_n),
    .stepper_supply_relay_n(stepper_supply_relay_n),
    .sensor_supply_relay_n(sensor_supply_relay_n),
    .fold_supply_relay_n(fold_supply_relay_n),
    .fold_out_cmd_n(fold_out_cmd_n), .fold_in_cmd_n(fold_in_cmd_n),
    .fold_in_relay_a_n(fold_in_relay_a_n),
    .fold_in_relay_b_n(fold_in_relay_b_n),
    .fold_out_relay_a_n(fold_out_relay_a_n),
    .fold_out_relay_b_n(fold_out_relay_b_n),
    .left_cover_switch(left_cover_switch),
    .right_cover_switch(right_cover_switch),
    .left_cover_open(left_cover_open), .right_cover_open(right_cover_open),
    .covers_clear(covers_clear), .fold_in_switch(fold_in_switch),
    .torque_switch_1(torque_switch_1), .torque_switch_2(torque_switch_2),
    .fold_out_switch(fold_out_switch), .fold_in_seen(fold_in_seen),
    .fold_out_seen_n(fold_out_seen_n), .limit_switch(limit_switch),
    .limit_status(limit_status), .load_count(load_count),
    .load_in_window(load_in_window), .load_offset(load_offset)
  );

  stepper_model partner (
    .clock(clock), .step(stepper_step), .dir(stepper_dir),
    .supply_n(stepper_supply_relay_n), .pos(pos)
  );

  // Free-running clock
  always #50 clock = ~clock;

  // Inputs move at the falling edge, outputs are read there too
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task t_supply;
    for (int v = 0; v < 8; v++) begin
      {stepper_power_n, position_sensor_power_n, fold_motor_power_n} = v;
      cyc(1);
      chk(supply_drv, v[2:0]);
    end
    $display("t_supply done");
  endtask : t_supply

  task t_fold;
    logic l, r, o, i, go_out, go_in;
    for (int v = 0; v < 16; v++) begin
      {l, r, o, i} = v[3:0];
      {left_cover_switch, right_cover_switch} = {l, r};
      {fold_out_cmd_n, fold_in_cmd_n} = {o, i};
      cyc(2);
      go_out = l & r & !o & i;
      go_in = l & r & !i & o;
      chk(fold_drv, {!go_in, !go_in, !go_out, !go_out});
      chk({left_cover_open, right_cover_open}, {l, r});
      chk(covers_clear, l & r);
    end
    $display("t_fold done");
  endtask : t_fold

  task t_status;
    for (int v = 0; v < 16; v++) begin
      {fold_in_switch, torque_switch_1, torque_switch_2} = v[3:1];
      fold_out_switch = v[0];
      limit_switch = {v[1:0], v[3:0]};
      cyc(1);
      chk({fold_in_seen, fold_out_seen_n}, {&v[3:1], !v[0]});
      chk(limit_status, {v[1:0], v[3:0]});
    end
    $display("t_status done");
  endtask : t_status

  task t_load;
    load_count = {12'h70d, 12'h69f, 12'h69e};
    cyc(1);
    chk(load_in_window, 3'h6);
    chk(load_offset, {12'hf0e, 12'hea0, 12'he9f});
    load_count = {12'h000, 12'hfff, 12'h70e};
    cyc(1);
    chk(load_in_window, 3'h0);
    chk(load_offset, {12'h801, 12'h800, 12'hf0f});
    $display("t_load done");
  endtask : t_load

  task t_step;
    step_total = {16'h3, 16'h2, 16'h1};
    step_clockwise = 3'h5;
    step_start = 3'h7;
    cyc(2);
    chk(step_busy, 3'h0);
    step_start = 3'h0;
    stepper_power_n = 1'b0;
    cyc(2);
    step_start = 3'h7;
    cyc(1);
    step_start = 3'h0;
    for (int k = 0; k < 300 && step_busy !== 3'h0; k++) cyc(1);
    chk(step_busy, 3'h0);
    chk(pos[0], 1);
    chk(pos[1], -2);
    chk(pos[2], 3);
    chk(step_remain, 48'h0);
    // Abort in the gap after the first of five pulses
    step_total[47:32] = 16'h5;
    step_start = 3'h4;
    cyc(1);
    step_start = 3'h0;
    cyc(14);
    step_abort = 3'h4;
    cyc(1);
    step_abort = 3'h0;
    cyc(2);
    chk({step_busy, stepper_step}, 6'h0);
    chk(pos[2], 4);
    $display("t_step done");
  endtask : t_step

  // Main sequence, reset held for six edges
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    {stepper_power_n, position_sensor_power_n, fold_motor_power_n} = 3'h7;
    {fold_out_cmd_n, fold_in_cmd_n, left_cover_switch} = 3'h6;
    {right_cover_switch, fold_in_switch, fold_out_switch} = 3'h0;
    {torque_switch_1, torque_switch_2} = 2'h0;
    {step_start, step_clockwise, step_abort} = 9'h0;
    {step_total, limit_switch, load_count} = 90'h0;
    mismatches = 0;
    checks = 0;
    cyc(6);
    chk({supply_drv, fold_drv, fold_out_seen_n}, 8'hff);
    rst_b = 1'b1;
    t_supply;
    t_fold;
    t_status;
    t_load;
    t_step;
    test_done;
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    test_done;
  end
endmodule : optics_actuator_control_tb
`default_nettype wire
